// file: core/plt_defines.vh
`ifndef PLT_DEFINES_VH
`define PLT_DEFINES_VH

// ==========================================================
// register-select decode
`define PLT_RS_PTR_WR 3'h0
`define PLT_RS_PAL_DATA 3'h1
`define PLT_RS_MASK 3'h2
`define PLT_RS_PTR_RD 3'h3
`define PLT_RS_OVL_PTR_WR 3'h4
`define PLT_RS_OVL_DATA 3'h5
`define PLT_RS_RESVD 3'h6
`define PLT_RS_OVL_PTR_RD 3'h7

// ==========================================================
// select bit positions
`define PLT_RS_OVL_BIT 2
`define PLT_RS_READ_BIT 1

// ==========================================================
// color phase codes
`define PLT_PHASE_RED 2'h0
`define PLT_PHASE_GREEN 2'h1
`define PLT_PHASE_BLUE 2'h2

// ==========================================================
// reset values
`define PLT_PTR_RESET 8'h00
`define PLT_MASK_RESET 8'h00
`define PLT_HOLD_RESET 8'h00
`define PLT_RDATA_RESET 8'h00
`define PLT_WORD_RESET 24'h000000

// ==========================================================
// misc constants
`define PLT_OVL_RESVD 4'h0
`define PLT_LOW_PAD 2'h0
`define PLT_PIPE_LATENCY 3

`endif

// file: core/plt_palette_ram.v
`timescale 1ns/1ps

// ==========================================================
// two-port palette storage, registered read data on both ports
// no reset on the array: contents are undefined until written
module plt_palette_ram #(
  parameter AW = 8,
  parameter DW = 24
) (
  input wire core_clk,
  input wire ce,
  input wire a_we,
  input wire [AW-1:0] a_addr,
  input wire [DW-1:0] a_wdata,
  output reg [DW-1:0] a_rdata,
  input wire [AW-1:0] b_addr,
  output reg [DW-1:0] b_rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge core_clk)
  begin
    if (ce)
    begin
      if (a_we)
      begin
        mem[a_addr] <= a_wdata;
      end
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end

endmodule

// file: core/plt_core.v
`timescale 1ns/1ps
`include "plt_defines.vh"

module plt_core #(
  parameter CW = 8,
  parameter AW = 8,
  parameter N_OVL = 15
) (
  input wire core_clk,
  input wire rst,
  input wire ce,
  input wire [2:0] register_select,
  input wire host_wr,
  input wire host_rd,
  input wire [CW-1:0] host_data_in,
  output reg [CW-1:0] host_data_out,
  output reg host_data_oe,
  input wire color_width_8,
  input wire [AW-1:0] pixel_index_inputs,
  input wire [3:0] overlay_select_inputs,
  input wire sync_n,
  input wire blank_n,
  input wire pedestal_sel,
  output reg [CW-1:0] dac_red,
  output reg [CW-1:0] dac_green,
  output reg [CW-1:0] dac_blue,
  output reg dac_sync_n,
  output reg dac_blank_n,
  output reg dac_pedestal
);

  localparam WW = 3 * CW;
  localparam ST_IDLE = 1'b0;
  localparam ST_FETCH = 1'b1;

  // ==========================================================
  // functions
  function [CW-1:0] store_color;
    input [CW-1:0] d;
    input w8;
    begin
      store_color = w8 ? d : {d[CW-3:0], `PLT_LOW_PAD};
    end
  endfunction

  function [CW-1:0] host_color;
    input [CW-1:0] v;
    input w8;
    begin
      host_color = w8 ? v : {`PLT_LOW_PAD, v[CW-1:2]};
    end
  endfunction

  function [CW-1:0] dac_code;
    input [CW-1:0] v;
    input w8;
    begin
      dac_code = w8 ? v : {v[CW-1:2], `PLT_LOW_PAD};
    end
  endfunction

  function is_ptr_sel;
    input [2:0] rs;
    begin
      is_ptr_sel = (rs == `PLT_RS_PTR_WR) || (rs == `PLT_RS_PTR_RD) ||
                   (rs == `PLT_RS_OVL_PTR_WR) || (rs == `PLT_RS_OVL_PTR_RD);
    end
  endfunction

  function [WW-1:0] ovl_pick;
    input [WW*N_OVL-1:0] f;
    input [3:0] idx;
    integer k;
    begin
      ovl_pick = `PLT_WORD_RESET;
      for (k = 1; k <= N_OVL; k = k + 1)
      begin
        if (idx == k[3:0])
        begin
          ovl_pick = f[(k-1)*WW +: WW];
        end
      end
    end
  endfunction

  // ==========================================================
  // host side state
  reg [AW-1:0] pointer_bits;
  reg [1:0] phase;
  reg [CW-1:0] pixel_mask;
  reg [CW-1:0] hold_r;
  reg [CW-1:0] hold_g;
  reg [CW-1:0] hold_b;
  reg pend_load;
  reg pend_store;
  reg pend_ovl;
  reg state;
  reg [WW*N_OVL-1:0] ovl_flat;

  wire host_act;
  wire commit_store;
  wire ram_we;
  wire ovl_we;
  wire [WW-1:0] ram_a_rdata;
  wire [WW-1:0] ram_b_rdata;
  wire [WW-1:0] hold_word;
  wire [WW-1:0] fetch_word;
  wire [3:0] ovl_index;
  wire [AW-1:0] masked_pix;

  // transfers only in cycles without a host strobe, so a host access never
  // collides with the storage port; bursts must leave idle gaps
  assign host_act = host_wr | host_rd;
  assign commit_store = ce & ~host_act & (state == ST_IDLE) & pend_store;
  assign ovl_index = pointer_bits[3:0];
  assign ram_we = commit_store & ~pend_ovl;
  assign ovl_we = commit_store & pend_ovl & (ovl_index != `PLT_OVL_RESVD);
  assign hold_word = {hold_r, hold_g, hold_b};
  assign fetch_word = pend_ovl ? ovl_pick(ovl_flat, ovl_index) : ram_a_rdata;

  // ==========================================================
  // host register access and transfer sequencing
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pointer_bits <= `PLT_PTR_RESET;
      phase <= `PLT_PHASE_RED;
      pixel_mask <= `PLT_MASK_RESET;
      hold_r <= `PLT_HOLD_RESET;
      hold_g <= `PLT_HOLD_RESET;
      hold_b <= `PLT_HOLD_RESET;
      pend_load <= 1'b0;
      pend_store <= 1'b0;
      pend_ovl <= 1'b0;
      state <= ST_IDLE;
      host_data_out <= `PLT_RDATA_RESET;
      host_data_oe <= 1'b0;
    end
    else if (ce)
    begin
      host_data_oe <= host_rd & ~host_wr;
      if (host_wr)
      begin
        if (is_ptr_sel(register_select))
        begin
          pointer_bits <= host_data_in;
          phase <= `PLT_PHASE_RED;
          pend_store <= 1'b0;
          pend_load <= register_select[`PLT_RS_READ_BIT];
          pend_ovl <= register_select[`PLT_RS_OVL_BIT];
          state <= ST_IDLE;
        end
        else
        begin
          case (register_select)
            `PLT_RS_MASK:
            begin
              pixel_mask <= host_data_in;
            end
            `PLT_RS_PAL_DATA, `PLT_RS_OVL_DATA:
            begin
              case (phase)
                `PLT_PHASE_RED:
                begin
                  hold_r <= store_color(host_data_in, color_width_8);
                  phase <= `PLT_PHASE_GREEN;
                end
                `PLT_PHASE_GREEN:
                begin
                  hold_g <= store_color(host_data_in, color_width_8);
                  phase <= `PLT_PHASE_BLUE;
                end
                default:
                begin
                  hold_b <= store_color(host_data_in, color_width_8);
                  phase <= `PLT_PHASE_RED;
                  pend_store <= 1'b1;
                  pend_load <= 1'b0;
                  pend_ovl <= register_select[`PLT_RS_OVL_BIT];
                end
              endcase
            end
            default:
            begin
              // reserved select: write has no effect
            end
          endcase
        end
      end
      else if (host_rd)
      begin
        if (is_ptr_sel(register_select))
        begin
          host_data_out <= pointer_bits;
        end
        else
        begin
          case (register_select)
            `PLT_RS_MASK:
            begin
              host_data_out <= pixel_mask;
            end
            `PLT_RS_PAL_DATA, `PLT_RS_OVL_DATA:
            begin
              case (phase)
                `PLT_PHASE_RED:
                begin
                  host_data_out <= host_color(hold_r, color_width_8);
                  phase <= `PLT_PHASE_GREEN;
                end
                `PLT_PHASE_GREEN:
                begin
                  host_data_out <= host_color(hold_g, color_width_8);
                  phase <= `PLT_PHASE_BLUE;
                end
                default:
                begin
                  host_data_out <= host_color(hold_b, color_width_8);
                  phase <= `PLT_PHASE_RED;
                  pend_load <= 1'b1;
                  pend_store <= 1'b0;
                  pend_ovl <= register_select[`PLT_RS_OVL_BIT];
                end
              endcase
            end
            default:
            begin
              host_data_out <= `PLT_RDATA_RESET;
            end
          endcase
        end
      end
      else
      begin
        case (state)
          ST_FETCH:
          begin
            hold_r <= fetch_word[3*CW-1:2*CW];
            hold_g <= fetch_word[2*CW-1:CW];
            hold_b <= fetch_word[CW-1:0];
            pointer_bits <= pointer_bits + 1'b1;
            pend_load <= 1'b0;
            state <= ST_IDLE;
          end
          default:
          begin
            if (pend_store)
            begin
              pointer_bits <= pointer_bits + 1'b1;
              pend_store <= 1'b0;
            end
            else if (pend_load)
            begin
              // storage read data is valid one cycle after the address settles
              state <= ST_FETCH;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // overlay color registers, flops so the pixel path reads them freely
  always @(posedge core_clk or posedge rst)
  begin : ovl_store
    integer k;
    if (rst)
    begin
      ovl_flat <= {(WW*N_OVL){1'b0}};
    end
    else if (ce && ovl_we)
    begin
      for (k = 1; k <= N_OVL; k = k + 1)
      begin
        if (ovl_index == k[3:0])
        begin
          ovl_flat[(k-1)*WW +: WW] <= hold_word;
        end
      end
    end
  end

  // ==========================================================
  // pixel pipeline: input regs, lookup, output regs
  reg [AW-1:0] pix_q;
  reg [3:0] ovs_q;
  reg [3:0] ovs_q2;
  reg [1:0] sync_p;
  reg [1:0] blank_p;
  reg [1:0] ped_p;
  wire [WW-1:0] pix_word;

  assign masked_pix = pix_q & pixel_mask;
  assign pix_word = (ovs_q2 != `PLT_OVL_RESVD) ? ovl_pick(ovl_flat, ovs_q2) : ram_b_rdata;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pix_q <= {AW{1'b0}};
      ovs_q <= 4'h0;
      ovs_q2 <= 4'h0;
      sync_p <= 2'h0;
      blank_p <= 2'h0;
      ped_p <= 2'h0;
    end
    else if (ce)
    begin
      pix_q <= pixel_index_inputs;
      ovs_q <= overlay_select_inputs;
      ovs_q2 <= ovs_q;
      sync_p <= {sync_p[0], sync_n};
      blank_p <= {blank_p[0], blank_n};
      ped_p <= {ped_p[0], pedestal_sel};
    end
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dac_red <= `PLT_RDATA_RESET;
      dac_green <= `PLT_RDATA_RESET;
      dac_blue <= `PLT_RDATA_RESET;
      dac_sync_n <= 1'b0;
      dac_blank_n <= 1'b0;
      dac_pedestal <= 1'b0;
    end
    else if (ce)
    begin
      dac_sync_n <= sync_p[1];
      dac_blank_n <= blank_p[1];
      dac_pedestal <= ped_p[1];
      if (!blank_p[1])
      begin
        dac_red <= `PLT_RDATA_RESET;
        dac_green <= `PLT_RDATA_RESET;
        dac_blue <= `PLT_RDATA_RESET;
      end
      else
      begin
        dac_red <= dac_code(pix_word[3*CW-1:2*CW], color_width_8);
        dac_green <= dac_code(pix_word[2*CW-1:CW], color_width_8);
        dac_blue <= dac_code(pix_word[CW-1:0], color_width_8);
      end
    end
  end

  // ==========================================================
  // palette storage
  plt_palette_ram #(
    .AW(AW),
    .DW(WW)
  ) u_ram (
    .core_clk(core_clk),
    .ce(ce),
    .a_we(ram_we),
    .a_addr(pointer_bits),
    .a_wdata(hold_word),
    .a_rdata(ram_a_rdata),
    .b_addr(masked_pix),
    .b_rdata(ram_b_rdata)
  );

endmodule

// file: dv/plt_core_checker.sv
`timescale 1ns/1ps
// =====
// port checker for the palette core
module plt_core_checker #(
  parameter CW = 8
) (
  input wire core_clk,
  input wire rst,
  input wire ce,
  input wire [2:0] register_select,
  input wire host_wr,
  input wire host_rd,
  input wire [CW-1:0] host_data_out,
  input wire host_data_oe,
  input wire color_width_8,
  input wire sync_n,
  input wire blank_n,
  input wire pedestal_sel,
  input wire [CW-1:0] dac_red,
  input wire [CW-1:0] dac_green,
  input wire [CW-1:0] dac_blue,
  input wire dac_sync_n,
  input wire dac_blank_n,
  input wire dac_pedestal
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // write wins when both strobes are high
  wire rd_take = ce && host_rd && !host_wr;

  a_oe_after_read: assert property (rd_take |=> host_data_oe)
    else $error("oe missing after read");
  a_oe_no_read: assert property (ce && !rd_take |=> !host_data_oe)
    else $error("oe without read");
  a_rdata_hold: assert property (!rd_take |=> $stable(host_data_out))
    else $error("read data moved");
  a_reserved_zero: assert property (rd_take && register_select == 3'h6 |=> host_data_out == 8'h00)
    else $error("reserved read not zero");
  a_six_read: assert property (rd_take && !color_width_8 && register_select[1:0] == 2'h1
    |=> host_data_out[7:6] == 2'h0)
    else $error("six-bit read top bits set");
  a_six_dac: assert property ((ce && !color_width_8)[*4]
    |-> {dac_red[1:0], dac_green[1:0], dac_blue[1:0]} == 6'h00)
    else $error("six-bit dac low bits set");
  a_blank_zero: assert property (ce[*4] ##0 !$past(blank_n, 3)
    |-> {dac_red, dac_green, dac_blue} == 24'h000000 && !dac_blank_n)
    else $error("blank not zero");
  // full ce run keeps the three-stage history meaningful
  a_sync_align: assert property (ce[*4] |-> dac_sync_n == $past(sync_n, 3) && dac_blank_n == $past(blank_n, 3))
    else $error("sync or blank misaligned");
  a_pedestal_pass: assert property (ce[*4] |-> dac_pedestal == $past(pedestal_sel, 3))
    else $error("pedestal misaligned");

  c_pal_read: cover property (rd_take && register_select == 3'h1);
  c_ovl_ptr: cover property (rd_take && register_select == 3'h7);
  c_blank: cover property (ce && !blank_n);
endmodule

bind plt_core plt_core_checker #(.CW(CW)) i_chk (
  .core_clk,
  .rst,
  .ce,
  .register_select,
  .host_wr,
  .host_rd,
  .host_data_out,
  .host_data_oe,
  .color_width_8,
  .sync_n,
  .blank_n,
  .pedestal_sel,
  .dac_red,
  .dac_green,
  .dac_blue,
  .dac_sync_n,
  .dac_blank_n,
  .dac_pedestal
);

// file: dv/plt_host_model.sv
`timescale 1ns/1ps
// =====
// host processor: one strobe per access, two idle edges after each
module plt_host_model (
  input wire core_clk,
  input wire [7:0] host_data_out,
  input wire host_data_oe,
  output logic [2:0] register_select,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_data_in
);
  initial
  begin
    register_select = 3'h0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_data_in = 8'h00;
  end

  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge core_clk);
    register_select <= s;
    host_data_in <= d;
    host_wr <= 1'b1;
    @(posedge core_clk);
    host_wr <= 1'b0;
    // released bus must not keep showing the old byte
    host_data_in <= ~d;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [2:0] s, output logic [7:0] d, output logic oe);
    @(posedge core_clk);
    register_select <= s;
    host_rd <= 1'b1;
    @(posedge core_clk);
    host_rd <= 1'b0;
    // oe stands for one cycle only, so take the answer before the next edge drops it
    #1;
    d = host_data_out;
    oe = host_data_oe;
    @(posedge core_clk);
  endtask
endmodule

// file: dv/test_plt_core.sv
`timescale 1ns/1ps
// =====
// bench with a reference model of pointer, phase and storage
module test_plt_core;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic color_width_8 = 1'b1;
  logic ce = 1'b1;
  logic [23:0] frz;
  logic [7:0] pixel_index_inputs = 8'h00;
  logic [3:0] overlay_select_inputs = 4'h0;
  logic sync_n = 1'b0;
  // bulk host traffic runs while the pixel side is blanked
  logic blank_n = 1'b0;
  logic pedestal_sel = 1'b0;
  wire [2:0] register_select;
  wire host_wr;
  wire host_rd;
  wire [7:0] host_data_in;
  wire [7:0] host_data_out;
  wire host_data_oe;
  wire [7:0] dac_red;
  wire [7:0] dac_green;
  wire [7:0] dac_blue;
  wire dac_sync_n;
  wire dac_blank_n;
  wire dac_pedestal;
  logic [23:0] pal [0:255];
  logic [23:0] ovl [0:15];
  logic [23:0] hold;
  logic [7:0] col [0:2];
  logic [7:0] mask = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic [31:0] seed = 32'h0000003A;
  logic [31:0] r;
  int ph = 0;
  int i;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;

  always #4 core_clk = ~core_clk;

  plt_core i_dut (
    .core_clk,
    .rst,
    .ce,
    .register_select,
    .host_wr,
    .host_rd,
    .host_data_in,
    .host_data_out,
    .host_data_oe,
    .color_width_8,
    .pixel_index_inputs,
    .overlay_select_inputs,
    .sync_n,
    .blank_n,
    .pedestal_sel,
    .dac_red,
    .dac_green,
    .dac_blue,
    .dac_sync_n,
    .dac_blank_n,
    .dac_pedestal
  );

  plt_host_model i_host (
    .core_clk,
    .host_data_out,
    .host_data_oe,
    .register_select,
    .host_wr,
    .host_rd,
    .host_data_in
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_of_test();
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_rd(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_px(input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR dac exp %h got %h", e, g);
    end
  endtask

  task automatic fetch(input logic o);
    hold = o ? ovl[ptr[3:0]] : pal[ptr];
    ptr = ptr + 8'h01;
  endtask

  // bus first, model after, so a width change just made has landed
  task automatic bw(input logic [2:0] s, input logic [7:0] d);
    i_host.wr(s, d);
    if (s[1:0] == 2'h1)
    begin
      col[ph] = color_width_8 ? d : {d[5:0], 2'h0};
      ph = ph + 1;
      if (ph == 3)
      begin
        if (!s[2])
          pal[ptr] = {col[0], col[1], col[2]};
        else if (ptr[3:0] != 4'h0)
          ovl[ptr[3:0]] = {col[0], col[1], col[2]};
        ptr = ptr + 8'h01;
        ph = 0;
      end
    end
    else if (s == 3'h2)
      mask = d;
    else if (s != 3'h6)
    begin
      ptr = d;
      ph = 0;
      if (s[1:0] == 2'h3)
        fetch(s[2]);
    end
  endtask

  task automatic br(input logic [2:0] s);
    logic [7:0] e;
    logic [7:0] g;
    logic oe;
    i_host.rd(s, g, oe);
    e = 8'h00;
    if (s[1:0] == 2'h1)
    begin
      e = hold[23 - 8 * ph -: 8];
      if (!color_width_8)
        e = {2'h0, e[7:2]};
      ph = ph + 1;
      if (ph == 3)
      begin
        fetch(s[2]);
        ph = 0;
      end
    end
    else if (s == 3'h2)
      e = mask;
    else if (s != 3'h6)
      e = ptr;
    chk_rd("rdata", e, g);
    chk_rd("oe", 8'h01, {7'h00, oe});
  endtask

  task automatic pix(input int n);
    logic [23:0] q [$];
    logic [23:0] e;
    for (int k = 0; k < n; k++)
    begin
      @(posedge core_clk);
      r = xs();
      pixel_index_inputs <= r[7:0];
      overlay_select_inputs <= r[12] ? r[11:8] : 4'h0;
      sync_n <= r[13];
      blank_n <= r[14] | r[15];
      pedestal_sel <= r[16];
      e = (r[12] && r[11:8] != 4'h0) ? ovl[r[11:8]] : pal[r[7:0] & mask];
      if (!(r[14] | r[15]))
        e = 24'h000000;
      if (!color_width_8)
        e = e & 24'hFCFCFC;
      q.push_back(e);
      #1;
      // driven at edge k, sampled at k+1, shown after edge k+3
      if (q.size() == 4)
        chk_px(q.pop_front(), {dac_red, dac_green, dac_blue});
    end
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    for (i = 0; i < 16; i++)
      ovl[i] = 24'h000000;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    bw(3'h2, 8'h01);
    br(3'h2);
    bw(3'h0, 8'hFE);
    for (i = 0; i < 12; i++)
    begin
      r = xs();
      bw(3'h1, r[7:0]);
    end
    br(3'h0);
    br(3'h6);
    bw(3'h6, 8'h5A);
    bw(3'h3, 8'hFF);
    for (i = 0; i < 9; i++)
      br(3'h1);
    bw(3'h4, 8'h31);
    for (i = 0; i < 6; i++)
    begin
      r = xs();
      bw(3'h5, r[7:0]);
    end
    bw(3'h7, 8'hF0);
    for (i = 0; i < 6; i++)
      br(3'h5);
    pix(60);
    @(posedge core_clk);
    color_width_8 <= 1'b0;
    bw(3'h0, 8'h02);
    for (i = 0; i < 3; i++)
    begin
      r = xs();
      if (i == 2)
        br(3'h0);
      bw(3'h1, r[7:0]);
    end
    bw(3'h3, 8'h02);
    for (i = 0; i < 3; i++)
      br(3'h1);
    pix(30);
    // clock enable low must freeze the pixel outputs even as blank drops
    @(posedge core_clk);
    ce <= 1'b0;
    blank_n <= 1'b0;
    #1;
    frz = {dac_red, dac_green, dac_blue};
    repeat (4) @(posedge core_clk);
    #1;
    chk_px(frz, {dac_red, dac_green, dac_blue});
    @(posedge core_clk);
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    end_of_test();
  end
endmodule
